// ==== shared/intc_params.svh ====
// Register offsets, field positions and reset values of the interrupt acceptance block
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PRIORITY_LEVEL 8'h00
`define OFS_SOURCE_MASK 8'h04
`define OFS_SOURCE_UNMASK 8'h08
`define OFS_EVENT_CODE 8'h0c
`define OFS_SAVED_STATUS 8'h10
`define OFS_SAVED_PC 8'h14
`define OFS_SAVED_STACK 8'h18
`define OFS_VECTOR_BASE 8'h1c
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h24
`define OFS_PENDING 8'h28

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define SW_MASK_LSB 4
`define SW_HOLD_BIT 28
`define SW_BANK_BIT 29
`define SW_PRIV_BIT 30

// ----------------------------------------
// Vectoring and event codes
// ----------------------------------------
`define VECTOR_OFFSET 32'h0000_0600
`define EVENT_CODE_BASE 32'h0000_0200
`define EVENT_CODE_STEP 32'h0000_0020

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PRIORITY 32'h0000_0000
`define RST_SOURCE_MASK 32'hffff_ffff
`define RST_VECTOR_BASE 32'h0000_0000
`define RST_IRQ_MASK 2'h0

// ----------------------------------------
// Status event bits
// ----------------------------------------
`define IRQ_BIT_ACCEPT 0
`define IRQ_BIT_FORWARD 1
`define IRQ_BITS 2

`endif

// ==== shared/intc_pkg.sv ====
// Types shared by the interrupt acceptance block
package intc_pkg;
   typedef logic [3:0] level_t;
   typedef logic [31:0] word_t;
   typedef logic [2:0] src_idx_t;
endpackage : intc_pkg

// ==== src/interrupt_accept_sequencer.sv ====
// Interrupt acceptance sequencer with classic Wishbone register slave
//
// Functional notes
// RULE1: Highest programmed level wins; losers stay pending.
// RULE2: Equal levels resolved by fixed source order.
// RULE3: Forward only if level exceeds mask level.
// RULE4: CPU takes interrupts only between instructions.
// RULE5: Accepted source code loaded into event code.
// RULE6: Save status, program counter, general register 15.
// RULE7: Set hold, privilege, bank flags after save.
// RULE8: Jump to vector base plus 0x600.
// RULE9: Mask level unchanged by acceptance.
// RULE10: Handler clears flag, reads back, waits first.
// RULE11: Certain masks cleared only via unmask register.
// RULE12: Event code usable directly as branch offset.
// RULE13: Requests held until cleared, then re-evaluated.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "intc_params.svh"

module interrupt_accept_sequencer #(
   parameter int NUM_SRC = 8
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Request sources
   input wire logic [NUM_SRC-1:0] src_req_i,
   // CPU core
   input wire intc_pkg::word_t status_word_i,
   input wire intc_pkg::word_t program_counter_i,
   input wire intc_pkg::word_t general_reg_15_i,
   input wire logic insn_boundary_i,
   output logic cpu_req_o,
   output intc_pkg::level_t cpu_req_level_o,
   output logic accept_o,
   output intc_pkg::word_t new_status_word_o,
   output intc_pkg::word_t jump_addr_o,
   // Interrupt line
   output logic irq_o
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_n;
   logic rst_n;

   // Release retimed to the clock; assertion stays asynchronous
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   intc_pkg::word_t priority_level_reg_a;
   // Resets to all ones: nothing forwards until unmasked
   intc_pkg::word_t source_mask_reg_0;
   intc_pkg::word_t event_code_reg;
   intc_pkg::word_t saved_status_word;
   intc_pkg::word_t saved_program_counter;
   intc_pkg::word_t saved_stack_register;
   intc_pkg::word_t vector_base;
   logic [`IRQ_BITS-1:0] irq_status;
   logic [`IRQ_BITS-1:0] irq_mask;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Byte-lane merge of a write word
   function automatic intc_pkg::word_t merge_sel(input intc_pkg::word_t old_v,
         input intc_pkg::word_t new_v, input logic [3:0] sel);
      intc_pkg::word_t r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_sel

   // Four-bit level field of one source
   function automatic intc_pkg::level_t level_of(input intc_pkg::word_t prio, input int idx);
      return prio[idx*4 +: 4];
   endfunction : level_of

   // ----------------------------------------
   // Arbitration
   // ----------------------------------------
   logic [NUM_SRC-1:0] active;
   intc_pkg::level_t win_level;
   intc_pkg::src_idx_t win_idx;
   logic win_valid;

   // Masked sources never compete
   assign active = src_req_i & ~source_mask_reg_0[NUM_SRC-1:0]; // RULE13

   always_comb begin
      win_level = 4'h0;
      win_idx = 3'h0;
      win_valid = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         // Strict compare keeps the lower index on a tie
         if (active[i] && (!win_valid || level_of(priority_level_reg_a, i) > win_level)) begin // RULE1 RULE2
            win_level = level_of(priority_level_reg_a, i);
            win_idx = i[2:0];
            win_valid = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // CPU handshake
   // ----------------------------------------
   intc_pkg::level_t mask_level;
   logic forward;
   logic take;
   intc_pkg::word_t next_status;
   intc_pkg::word_t next_event_code;

   assign mask_level = status_word_i[`SW_MASK_LSB +: 4];
   // Level 0 never exceeds a mask level, so it never forwards
   assign forward = win_valid && (win_level > mask_level); // RULE3
   assign cpu_req_o = forward;
   assign cpu_req_level_o = forward ? win_level : 4'h0;
   // Hold flag blocks a second take until software releases it
   assign take = forward && insn_boundary_i && !status_word_i[`SW_HOLD_BIT]; // RULE4

   // Mask field passes through untouched
   assign next_status = status_word_i | (32'h1 << `SW_HOLD_BIT) // RULE7 RULE9
      | (32'h1 << `SW_PRIV_BIT) | (32'h1 << `SW_BANK_BIT);
   // Fixed step per source keeps handler table entries apart
   assign next_event_code = `EVENT_CODE_BASE + `EVENT_CODE_STEP * {29'h0, win_idx}; // RULE12

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         event_code_reg <= 32'h0;
         saved_status_word <= 32'h0;
         saved_program_counter <= 32'h0;
         saved_stack_register <= 32'h0;
         new_status_word_o <= 32'h0;
         jump_addr_o <= 32'h0;
         accept_o <= 1'b0;
      end else begin
         accept_o <= take;
         // Saved state is the CPU view in the take cycle
         if (take) begin
            event_code_reg <= next_event_code; // RULE5
            saved_status_word <= status_word_i; // RULE6
            saved_program_counter <= program_counter_i; // RULE6
            saved_stack_register <= general_reg_15_i; // RULE6
            new_status_word_o <= next_status; // RULE7
            jump_addr_o <= vector_base + `VECTOR_OFFSET; // RULE8
         end
      end
   end

   // ----------------------------------------
   // Wishbone decode
   // ----------------------------------------
   logic req;
   logic wr;
   logic rd;
   logic hit_prio;
   logic hit_mask;
   logic hit_unmask;
   logic hit_evt;
   logic hit_ssr;
   logic hit_spc;
   logic hit_sgr;
   logic hit_vbase;
   logic hit_ist;
   logic hit_imsk;
   logic hit_pend;
   intc_pkg::word_t rdata;
   intc_pkg::word_t wmask;

   // Ack gates the request so each ack lasts one cycle; a held strobe gets an ack every other cycle
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes and read clears act at the acknowledged edge
   assign wr = wb_ack_o && wb_we_i;
   assign rd = wb_ack_o && !wb_we_i;
   assign hit_prio = wb_adr_i == `OFS_PRIORITY_LEVEL;
   assign hit_mask = wb_adr_i == `OFS_SOURCE_MASK;
   assign hit_unmask = wb_adr_i == `OFS_SOURCE_UNMASK;
   assign hit_evt = wb_adr_i == `OFS_EVENT_CODE;
   assign hit_ssr = wb_adr_i == `OFS_SAVED_STATUS;
   assign hit_spc = wb_adr_i == `OFS_SAVED_PC;
   assign hit_sgr = wb_adr_i == `OFS_SAVED_STACK;
   assign hit_vbase = wb_adr_i == `OFS_VECTOR_BASE;
   assign hit_ist = wb_adr_i == `OFS_IRQ_STATUS;
   assign hit_imsk = wb_adr_i == `OFS_IRQ_MASK;
   assign hit_pend = wb_adr_i == `OFS_PENDING;
   assign wmask = merge_sel(32'h0, wb_dat_i, wb_sel_i);

   always_comb begin
      if (hit_prio) begin
         rdata = priority_level_reg_a;
      end else if (hit_mask) begin
         rdata = source_mask_reg_0;
      end else if (hit_evt) begin
         rdata = event_code_reg;
      end else if (hit_ssr) begin
         rdata = saved_status_word;
      end else if (hit_spc) begin
         rdata = saved_program_counter;
      end else if (hit_sgr) begin
         rdata = saved_stack_register;
      end else if (hit_vbase) begin
         rdata = vector_base;
      end else if (hit_ist) begin
         rdata = {30'h0, irq_status};
      end else if (hit_imsk) begin
         rdata = {30'h0, irq_mask};
      end else if (hit_pend) begin
         rdata = {{(32-NUM_SRC){1'b0}}, src_req_i};
      end else begin
         rdata = 32'h0;
      end
   end

   // One wait state: ack and data one edge after the request
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rdata : 32'h0;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         priority_level_reg_a <= `RST_PRIORITY;
         source_mask_reg_0 <= `RST_SOURCE_MASK;
         vector_base <= `RST_VECTOR_BASE;
         irq_mask <= `RST_IRQ_MASK;
      end else begin
         // Unmapped offsets and read-only registers ignore writes
         if (wr && hit_prio) begin
            priority_level_reg_a <= merge_sel(priority_level_reg_a, wb_dat_i, wb_sel_i);
         end
         // Ones set masks; zeros are ignored, clearing goes via unmask
         if (wr && hit_mask) begin
            source_mask_reg_0 <= source_mask_reg_0 | wmask; // RULE11
         end else if (wr && hit_unmask) begin
            source_mask_reg_0 <= source_mask_reg_0 & ~wmask; // RULE11
         end
         if (wr && hit_vbase) begin
            vector_base <= merge_sel(vector_base, wb_dat_i, wb_sel_i);
         end
         if (wr && hit_imsk && wb_sel_i[0]) begin
            irq_mask <= wb_dat_i[`IRQ_BITS-1:0];
         end
      end
   end

   // ----------------------------------------
   // Sticky events, cleared by read
   // ----------------------------------------
   logic forward_q;
   logic [`IRQ_BITS-1:0] ev;

   assign ev[`IRQ_BIT_ACCEPT] = take;
   // Forward event marks the rising edge of the CPU request
   assign ev[`IRQ_BIT_FORWARD] = forward && !forward_q;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         forward_q <= 1'b0;
         irq_status <= '0;
      end else begin
         forward_q <= forward;
         // Set beats a clearing read in the same cycle
         irq_status <= ((rd && hit_ist) ? '0 : irq_status) | ev;
      end
   end

   // Level output, high while any unmasked event is held
   assign irq_o = |(irq_status & irq_mask);

endmodule : interrupt_accept_sequencer

// ==== testbench/intc_assertions.sv ====
// Port assertions of the interrupt acceptance block
`timescale 1ns/10ps
module intc_assertions (
   // Clock, reset and bus
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // CPU link and interrupt line
   input wire intc_pkg::word_t status_word_i,
   input wire logic insn_boundary_i,
   input wire logic cpu_req_o,
   input wire intc_pkg::level_t cpu_req_level_o,
   input wire logic accept_o,
   input wire intc_pkg::word_t new_status_word_o,
   input wire logic irq_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   wire logic take = cpu_req_o && insn_boundary_i && !status_word_i[28];
   property p_fwd; cpu_req_o |-> cpu_req_level_o > status_word_i[7:4]; endproperty
   a_fwd: assert property (p_fwd) else $error("forward at or below mask level");
   property p_idle; !cpu_req_o |-> cpu_req_level_o == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("level shown without forward");
   property p_take; take |=> accept_o; endproperty
   a_take: assert property (p_take) else $error("take not answered");
   property p_cause; accept_o |-> $past(take); endproperty
   a_cause: assert property (p_cause) else $error("accept without take");
   property p_sw; accept_o |-> new_status_word_o == ($past(status_word_i) | 32'h7000_0000); endproperty
   a_sw: assert property (p_sw) else $error("status word after take wrong");
   property p_hold; status_word_i[28] |=> !accept_o; endproperty
   a_hold: assert property (p_hold) else $error("take while hold flag set");
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("bus request not acknowledged");
   property p_ack1; wb_ack_o |=> !wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("acknowledge longer than one cycle");
   c_acc: cover property (accept_o);
   c_irq: cover property (irq_o);
   c_wait: cover property (cpu_req_o && !insn_boundary_i);
endmodule : intc_assertions

bind interrupt_accept_sequencer intc_assertions u_chk (.mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .status_word_i, .insn_boundary_i, .cpu_req_o, .cpu_req_level_o, .accept_o, .new_status_word_o, .irq_o);

// ==== testbench/cpu_core_model.sv ====
// CPU core model facing the acceptance block
`timescale 1ns/10ps
module cpu_core_model (
   // Clock, reset and bench control
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire intc_pkg::level_t mask_level_i,
   input wire logic clr_hold_i,
   // Acceptance block side
   input wire logic accept_i,
   input wire intc_pkg::word_t new_status_word_i,
   input wire intc_pkg::word_t jump_addr_i,
   output intc_pkg::word_t status_word_o,
   output intc_pkg::word_t program_counter_o,
   output intc_pkg::word_t general_reg_15_o,
   output logic insn_boundary_o
);
   assign general_reg_15_o = 32'h0000_7ff0;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_word_o <= 32'h0;
         program_counter_o <= 32'h0000_1000;
         insn_boundary_o <= 1'b0;
      end else begin
         insn_boundary_o <= !insn_boundary_o;
         status_word_o[7:4] <= mask_level_i;
         if (accept_i) begin
            status_word_o <= new_status_word_i;
            program_counter_o <= jump_addr_i;
         end else if (clr_hold_i) begin
            status_word_o[28] <= 1'b0;
         end
      end
   end
endmodule : cpu_core_model

// ==== testbench/interrupt_accept_sequencer_bench.sv ====
// Bench of the interrupt acceptance block
`timescale 1ns/10ps
module interrupt_accept_sequencer_bench;
   logic mclk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, clr_hold;
   logic insn_boundary_i, cpu_req_o, accept_o;
   logic [7:0] wb_adr_i, src_req_i;
   logic [3:0] wb_sel_i;
   intc_pkg::word_t wb_dat_i, wb_dat_o, status_word_i, program_counter_i, general_reg_15_i;
   intc_pkg::word_t new_status_word_o, jump_addr_o, rd;
   intc_pkg::level_t cpu_req_level_o, mask_lvl;
   logic [3:0] lanes = 4'hf;
   int error_cnt = 0;
   int n_tests = 0;
   interrupt_accept_sequencer uut (.mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .src_req_i, .status_word_i, .program_counter_i, .general_reg_15_i,
      .insn_boundary_i, .cpu_req_o, .cpu_req_level_o, .accept_o, .new_status_word_o, .jump_addr_o, .irq_o);
   cpu_core_model cpu (.mclk_i, .nrst_i, .mask_level_i(mask_lvl), .clr_hold_i(clr_hold), .accept_i(accept_o),
      .new_status_word_i(new_status_word_o), .jump_addr_i(jump_addr_o), .status_word_o(status_word_i),
      .program_counter_o(program_counter_i), .general_reg_15_o(general_reg_15_i),
      .insn_boundary_o(insn_boundary_i));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input intc_pkg::word_t seen, input intc_pkg::word_t exp);
      n_tests++;
      if (seen !== exp) begin
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         error_cnt++;
      end
   endtask : chk
   task automatic to(input logic ok);
      if (!ok) begin
         $display("[ERR] %0t wait ran out", $time);
         error_cnt++;
         close_out();
      end
   endtask : to
   // Classic single cycle, idle cycle after
   task automatic wb(input logic we, input logic [7:0] adr, input intc_pkg::word_t dat);
      int n;
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, lanes};
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge mclk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      to(wb_ack_o === 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge mclk_i);
   endtask : wb
   task automatic rc(input logic [7:0] adr, input intc_pkg::word_t exp);
      wb(1'b0, adr, 32'h0);
      chk(rd, exp);
   endtask : rc
   task automatic wacc();
      int n;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (accept_o !== 1'b1 && n < 20);
      to(accept_o === 1'b1);
   endtask : wacc
   task automatic unhold();
      clr_hold <= 1'b1;
      @(posedge mclk_i);
      clr_hold <= 1'b0;
   endtask : unhold
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   initial begin
      {nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, clr_hold} = 5'h0;
      {wb_adr_i, src_req_i, wb_sel_i, mask_lvl} = 24'h0;
      wb_dat_i = 32'h0;
      repeat (20) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rc(8'h04, 32'hffff_ffff);
      rc(8'h00, 32'h0);
      rc(8'h1c, 32'h0);
      lanes = 4'h2;
      wb(1'b1, 8'h1c, 32'h1234_5678);
      lanes = 4'hf;
      rc(8'h1c, 32'h0000_5600);
      wb(1'b1, 8'h3c, 32'hffff_ffff);
      rc(8'h3c, 32'h0);
      $display("test reset done");
      wb(1'b1, 8'h00, 32'h0060_0603);
      wb(1'b1, 8'h1c, 32'h8000_0000);
      wb(1'b1, 8'h08, 32'h0000_0025);
      wb(1'b1, 8'h04, 32'h0);
      rc(8'h04, 32'hffff_ffda);
      rc(8'h08, 32'h0);
      mask_lvl <= 4'h6;
      wb(1'b1, 8'h24, 32'h1);
      rc(8'h24, 32'h1);
      src_req_i <= 8'h25;
      repeat (4) @(posedge mclk_i);
      chk({31'h0, cpu_req_o}, 32'h0);
      rc(8'h28, 32'h25);
      chk({31'h0, irq_o}, 32'h0);
      mask_lvl <= 4'h5;
      wacc();
      chk(jump_addr_o, 32'h8000_0600);
      chk(new_status_word_o, 32'h7000_0050);
      rc(8'h0c, 32'h240);
      rc(8'h10, 32'h50);
      rc(8'h14, 32'h1000);
      rc(8'h18, 32'h7ff0);
      chk({31'h0, irq_o}, 32'h1);
      rc(8'h20, 32'h3);
      chk({31'h0, irq_o}, 32'h0);
      $display("test take done");
      src_req_i <= 8'h21;
      rc(8'h28, 32'h21);
      unhold();
      wacc();
      rc(8'h0c, 32'h2a0);
      rc(8'h14, 32'h8000_0600);
      rc(8'h10, 32'h6000_0050);
      src_req_i <= 8'h01;
      unhold();
      repeat (4) @(posedge mclk_i);
      chk({31'h0, cpu_req_o}, 32'h0);
      mask_lvl <= 4'h2;
      wacc();
      chk({28'h0, cpu_req_level_o}, 32'h3);
      rc(8'h0c, 32'h200);
      $display("test pending done");
      close_out();
   end
endmodule : interrupt_accept_sequencer_bench
